//--- logic/wdog_pkg.sv
// constants, field layout and state codes of the board watchdog
// assumes a 25 MHz core clock and byte-wide i/o register cycles
`default_nettype none
package wdog_pkg;

  // ----------------------------------------
  // register addresses in i/o space
  // ----------------------------------------
  localparam int          IO_AW      = 16;
  localparam logic [15:0] ADDR_UNIT  = 16'h0565;
  localparam logic [15:0] ADDR_VALUE = 16'h0566;
  localparam logic [15:0] ADDR_CFG   = 16'h0567;
  localparam logic [15:0] ADDR_CTRL  = 16'h0568;

  // ----------------------------------------
  // field positions and writable masks
  // ----------------------------------------
  localparam int         UNIT_SEC_BIT   = 7;
  localparam int         CFG_KBD_BIT    = 1;
  localparam int         CFG_MOUSE_BIT  = 2;
  localparam int         CTRL_DONE_BIT  = 0;
  localparam int         CTRL_FORCE_BIT = 2;
  localparam int         CTRL_KEY_BIT   = 3;
  localparam logic [7:0] UNIT_WR_MASK   = 8'h80;
  localparam logic [7:0] CFG_WR_MASK    = 8'h06;
  localparam logic [7:0] CTRL_WR_MASK   = 8'h08;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_UNIT  = 8'h00;
  localparam logic [7:0] RST_VALUE = 8'h00;
  localparam logic [7:0] RST_CFG   = 8'h00;
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] VALUE_OFF = 8'h00;
  localparam logic [7:0] VALUE_ONE = 8'h01;
  localparam logic [7:0] RD_NONE   = 8'h00;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int UNIT_SEC_NS   = 1000000000;
  localparam int SEC_CYCLES    = UNIT_SEC_NS / CLK_PERIOD_NS;
  localparam int SECS_PER_MIN  = 60;

  // ----------------------------------------
  // external event lines
  // ----------------------------------------
  localparam int EXT_N     = 3;
  localparam int EXT_KBD   = 0;
  localparam int EXT_MOUSE = 1;
  localparam int EXT_KEY   = 2;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_COUNT = 3'b010,
    ST_DONE  = 3'b100
  } wd_state_t;

  function automatic logic addr_hit(input logic [IO_AW-1:0] a, input logic [IO_AW-1:0] t);
    addr_hit = (a == t);
  endfunction

endpackage
`default_nettype wire

//--- logic/tick_if.sv
// time base link between watchdog core and its unit tick generator
// assumes both ends share one clock
`timescale 1ns/1ns
`default_nettype none
interface tick_if;
  logic restart;
  logic seconds_mode;
  logic unit_tick;

  modport gen  (input restart, input seconds_mode, output unit_tick);
  modport core (output restart, output seconds_mode, input unit_tick);
endinterface
`default_nettype wire

//--- logic/ext_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
// assumes inputs are asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module ext_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] lvl_nxt;

  // a change counts only once stages two and three agree
  assign lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
    end else begin
      s1_r  <= async_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_o = lvl_r;
  assign rise_o  = lvl_nxt & ~lvl_r;
endmodule
`default_nettype wire

//--- logic/unit_tick_gen.sv
// one-cycle pulse per elapsed second or minute
// assumes restart is held while the watchdog is not counting
`timescale 1ns/1ns
`default_nettype none
module unit_tick_gen
  import wdog_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES,
  parameter int MIN_SEC = SECS_PER_MIN
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  tick_if.gen       tk
);
  localparam int CW = $clog2(SEC_CYC + 1);
  localparam int MW = $clog2(MIN_SEC + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(SEC_CYC - 1);
  localparam logic [MW-1:0] SEC_LAST = MW'(MIN_SEC - 1);

  logic [CW-1:0] cyc_r;
  logic [MW-1:0] sec_r;
  logic          sec_wrap;
  logic          min_wrap;
  logic          tick_r;

  assign sec_wrap = (cyc_r == CYC_LAST);
  assign min_wrap = sec_wrap && (sec_r == SEC_LAST);

  // restart drops the partial unit so a reload always gets the full time
  always_ff @(posedge clk_i) begin
    if (rst_i || tk.restart) begin
      cyc_r  <= '0;
      sec_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cyc_r  <= sec_wrap ? '0 : cyc_r + CW'(1);
      sec_r  <= min_wrap ? '0 : (sec_wrap ? sec_r + MW'(1) : sec_r);
      tick_r <= tk.seconds_mode ? sec_wrap : min_wrap;
    end
  end

  assign tk.unit_tick = tick_r;
endmodule
`default_nettype wire

//--- logic/programmable_board_watchdog.sv
// second watchdog: four byte registers in i/o space, unit time base,
// restart by keyboard or mouse interrupt, forced trigger by write or key
// assumes single-cycle synchronous i/o strobes on MCLK_I
//
// Notes on behaviour
// R1 - four byte registers at 565h through 568h
// R2 - unit bit 7: zero minutes, one seconds
// R3 - timeout value counts selected units, 1..255
// R4 - value zero disables counting and triggering
// R5 - config bit 1 lets keyboard interrupt restart
// R6 - config bit 2 lets mouse interrupt restart
// R7 - control bit 0 reads one when expired
// R8 - writing control bit 2 triggers at once
// R9 - control bit 3 lets key press trigger
// R10 - software keeps reserved and config[7:4] zero
// R11 - expiry sets status and drives trigger output
// R12 - nonzero value write loads and starts countdown
`timescale 1ns/1ns
`default_nettype none
module programmable_board_watchdog
  import wdog_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES,
  parameter int MIN_SEC = SECS_PER_MIN
) (
  // clock and reset
  input  wire logic             MCLK_I,
  input  wire logic             RESET_I,
  // i/o register cycles
  input  wire logic [IO_AW-1:0] IO_ADDR_I,
  input  wire logic [7:0]       IO_WDATA_I,
  input  wire logic             IO_WR_I,
  input  wire logic             IO_RD_I,
  output logic      [7:0]       IO_RDATA_O,
  // event pins
  input  wire logic             KBD_IRQ_I,
  input  wire logic             MOUSE_IRQ_I,
  input  wire logic             KEY_PRESS_I,
  // status outputs
  output logic                  WDOG_TRIGGER_O,
  output logic                  WDOG_RUNNING_O
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  tick_if tk ();

  logic [7:0]      unit_r;
  logic [7:0]      value_r;
  logic [7:0]      cfg_r;
  logic [7:0]      ctrl_r;
  logic [7:0]      remain_r;
  logic [7:0]      remain_nxt;
  logic [7:0]      rdata_r;
  logic [7:0]      rdata_nxt;
  logic            trig_r;
  logic            run_r;
  wd_state_t       state_r;
  wd_state_t       state_nxt;
  logic [7:0]      unit_nxt;
  logic [7:0]      value_nxt;
  logic [7:0]      cfg_nxt;
  logic [7:0]      ctrl_nxt;
  logic            trig_nxt;
  logic            run_nxt;

  logic [EXT_N-1:0] ext_async;
  logic [EXT_N-1:0] ext_rise;

  logic            hit_unit;
  logic            hit_value;
  logic            hit_cfg;
  logic            hit_ctrl;
  logic            wr_unit;
  logic            wr_value;
  logic            wr_cfg;
  logic            wr_ctrl;
  logic            wr_start;
  logic            wr_stop;
  logic            counting;
  logic            force_evt;
  logic            key_evt;
  logic            kbd_restart;
  logic            mouse_restart;
  logic            restart_evt;
  logic            last_unit;
  logic            expire_evt;

  // ----------------------------------------
  // pin synchronisers and time base
  // ----------------------------------------
  assign ext_async[EXT_KBD]   = KBD_IRQ_I;
  assign ext_async[EXT_MOUSE] = MOUSE_IRQ_I;
  assign ext_async[EXT_KEY]   = KEY_PRESS_I;

  ext_sync #(
    .W (EXT_N)
  ) u_sync (
    .clk_i   (MCLK_I),
    .rst_i   (RESET_I),
    .async_i (ext_async),
    .level_o (),
    .rise_o  (ext_rise)
  );

  unit_tick_gen #(
    .SEC_CYC (SEC_CYC),
    .MIN_SEC (MIN_SEC)
  ) u_tick (
    .clk_i (MCLK_I),
    .rst_i (RESET_I),
    .tk    (tk.gen)
  );

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign hit_unit  = addr_hit(IO_ADDR_I, ADDR_UNIT);  // see R1
  assign hit_value = addr_hit(IO_ADDR_I, ADDR_VALUE); // see R1
  assign hit_cfg   = addr_hit(IO_ADDR_I, ADDR_CFG);   // see R1
  assign hit_ctrl  = addr_hit(IO_ADDR_I, ADDR_CTRL);  // see R1

  assign wr_unit  = IO_WR_I && hit_unit;
  assign wr_value = IO_WR_I && hit_value;
  assign wr_cfg   = IO_WR_I && hit_cfg;
  assign wr_ctrl  = IO_WR_I && hit_ctrl;

  assign wr_start = wr_value && (IO_WDATA_I != VALUE_OFF); // see R12
  assign wr_stop  = wr_value && (IO_WDATA_I == VALUE_OFF); // see R4

  // ----------------------------------------
  // event qualification
  // ----------------------------------------
  // nothing fires while disabled or already expired
  assign counting = (state_r == ST_COUNT);

  assign force_evt = wr_ctrl && IO_WDATA_I[CTRL_FORCE_BIT];          // see R8
  assign key_evt   = ext_rise[EXT_KEY] && ctrl_r[CTRL_KEY_BIT];      // see R9

  assign kbd_restart   = ext_rise[EXT_KBD] && cfg_r[CFG_KBD_BIT];       // see R5
  assign mouse_restart = ext_rise[EXT_MOUSE] && cfg_r[CFG_MOUSE_BIT];   // see R6
  assign restart_evt   = counting && (kbd_restart || mouse_restart);

  assign last_unit  = tk.unit_tick && (remain_r == VALUE_ONE);       // see R3
  // the trigger wins over a reload in the same cycle so it is never lost
  assign expire_evt = counting && (force_evt || key_evt || last_unit); // see R11

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (wr_start) begin
          state_nxt = ST_COUNT; // see R12
        end
      end
      ST_COUNT: begin
        if (expire_evt) begin
          state_nxt = ST_DONE; // see R11
        end else if (wr_stop) begin
          state_nxt = ST_OFF; // see R4
        end
      end
      ST_DONE: begin
        if (wr_start) begin
          state_nxt = ST_COUNT; // see R12
        end else if (wr_stop) begin
          state_nxt = ST_OFF; // see R4
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  // ----------------------------------------
  // remaining units
  // ----------------------------------------
  always_comb begin
    remain_nxt = remain_r;
    if (expire_evt) begin
      remain_nxt = VALUE_OFF;
    end else if (wr_start) begin
      remain_nxt = IO_WDATA_I; // see R12
    end else if (restart_evt) begin
      remain_nxt = value_r; // see R5 see R6
    end else if (counting && tk.unit_tick) begin
      remain_nxt = remain_r - VALUE_ONE; // see R3
    end
  end

  // partial unit is discarded on every (re)start and while idle
  assign tk.restart      = wr_start || restart_evt || !counting;
  assign tk.seconds_mode = unit_r[UNIT_SEC_BIT]; // see R2

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // reserved bits read as zero; force bit is write-only
  assign rdata_nxt = !IO_RD_I  ? rdata_r :
                     hit_unit  ? (unit_r & UNIT_WR_MASK) :
                     hit_value ? value_r :
                     hit_cfg   ? (cfg_r & CFG_WR_MASK) :
                     hit_ctrl  ? ((ctrl_r & CTRL_WR_MASK) | {7'h00, trig_r}) : // see R7
                                 RD_NONE;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // upper config bits are not stored, so a stray write there does no harm
  // one flop per block keeps every reset value beside its register
  assign unit_nxt  = wr_unit  ? (IO_WDATA_I & UNIT_WR_MASK) : unit_r; // see R2
  assign value_nxt = wr_value ? IO_WDATA_I : value_r;                 // see R3
  assign cfg_nxt   = wr_cfg   ? (IO_WDATA_I & CFG_WR_MASK) : cfg_r;   // see R5 see R6 see R10
  assign ctrl_nxt  = wr_ctrl  ? (IO_WDATA_I & CTRL_WR_MASK) : ctrl_r; // see R9

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      unit_r <= RST_UNIT;
    end else begin
      unit_r <= unit_nxt;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      value_r <= RST_VALUE;
    end else begin
      value_r <= value_nxt;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      cfg_r <= RST_CFG;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ctrl_r <= RST_CTRL;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ----------------------------------------
  // countdown state and outputs
  // ----------------------------------------
  // flags follow the next state so they never lag the state register
  assign trig_nxt = (state_nxt == ST_DONE);  // see R7 see R11
  assign run_nxt  = (state_nxt == ST_COUNT);

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      remain_r <= RST_VALUE;
    end else begin
      remain_r <= remain_nxt;
    end
  end

  // read data is held between reads so the host may sample it late
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rdata_r <= RD_NONE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= trig_nxt;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      run_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
    end
  end

  assign IO_RDATA_O     = rdata_r;
  assign WDOG_TRIGGER_O = trig_r;
  assign WDOG_RUNNING_O = run_r;

endmodule
`default_nettype wire

//--- dv/wdog_checker.sv
// concurrent checks on the board watchdog top ports
// assumes bind into programmable_board_watchdog, one clock domain
`timescale 1ns/1ns
`default_nettype none
module wdog_checker
  import wdog_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES,
  parameter int MIN_SEC = SECS_PER_MIN
) (
  // watched ports
  input wire logic             MCLK_I,
  input wire logic             RESET_I,
  input wire logic [IO_AW-1:0] IO_ADDR_I,
  input wire logic [7:0]       IO_WDATA_I,
  input wire logic             IO_WR_I,
  input wire logic             IO_RD_I,
  input wire logic [7:0]       IO_RDATA_O,
  input wire logic             KBD_IRQ_I,
  input wire logic             MOUSE_IRQ_I,
  input wire logic             KEY_PRESS_I,
  input wire logic             WDOG_TRIGGER_O,
  input wire logic             WDOG_RUNNING_O
);
  // ----
  // decode
  // ----
  wire logic rd_unit  = IO_RD_I && (IO_ADDR_I == ADDR_UNIT);
  wire logic rd_cfg   = IO_RD_I && (IO_ADDR_I == ADDR_CFG);
  wire logic rd_ctrl  = IO_RD_I && (IO_ADDR_I == ADDR_CTRL);
  wire logic rd_none  = IO_RD_I && !(IO_ADDR_I inside {[ADDR_UNIT:ADDR_CTRL]});
  wire logic wr_val   = IO_WR_I && (IO_ADDR_I == ADDR_VALUE);
  wire logic wr_force = IO_WR_I && (IO_ADDR_I == ADDR_CTRL) && IO_WDATA_I[CTRL_FORCE_BIT];

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  // ----
  // assertions
  // ----
  a_unmapped_reads_zero: assert property (rd_none |=> IO_RDATA_O == RD_NONE)
    else $error("unmapped read returned data");
  a_unit_reserved_zero: assert property (rd_unit |=> IO_RDATA_O[6:0] == 7'h00)
    else $error("unit register reserved bits set");
  a_cfg_fields_only: assert property (rd_cfg |=> (IO_RDATA_O & ~CFG_WR_MASK) == 8'h00)
    else $error("config register outside restart fields");
  a_status_bit_matches: assert property (rd_ctrl |=> IO_RDATA_O[0] == $past(WDOG_TRIGGER_O))
    else $error("status bit differs from trigger");
  a_force_trips_now: assert property (wr_force && WDOG_RUNNING_O |=> WDOG_TRIGGER_O)
    else $error("forced trigger late");
  a_zero_disables_all: assert property (wr_val && IO_WDATA_I == VALUE_OFF && !WDOG_RUNNING_O
    |=> (!WDOG_TRIGGER_O && !WDOG_RUNNING_O) [*2])
    else $error("zero value left timer active");
  a_load_starts_count: assert property (wr_val && IO_WDATA_I != VALUE_OFF && !WDOG_RUNNING_O
    |=> WDOG_RUNNING_O && !WDOG_TRIGGER_O)
    else $error("nonzero value did not start");
  a_trigger_holds_high: assert property (WDOG_TRIGGER_O && !wr_val |=> WDOG_TRIGGER_O)
    else $error("trigger dropped without value write");
  a_not_both_states: assert property (!(WDOG_TRIGGER_O && WDOG_RUNNING_O))
    else $error("running and expired together");
  a_rise_needs_run: assert property ($rose(WDOG_TRIGGER_O) |-> $past(WDOG_RUNNING_O))
    else $error("trigger without countdown");

  c_force: cover property (wr_force && WDOG_RUNNING_O);
  c_expire: cover property ($rose(WDOG_TRIGGER_O));
  c_stop: cover property ($fell(WDOG_RUNNING_O) && !WDOG_TRIGGER_O);
endmodule

bind programmable_board_watchdog wdog_checker #(.SEC_CYC(SEC_CYC), .MIN_SEC(MIN_SEC)) wdog_checker_i (
  .MCLK_I(MCLK_I), .RESET_I(RESET_I), .IO_ADDR_I(IO_ADDR_I), .IO_WDATA_I(IO_WDATA_I),
  .IO_WR_I(IO_WR_I), .IO_RD_I(IO_RD_I), .IO_RDATA_O(IO_RDATA_O), .KBD_IRQ_I(KBD_IRQ_I),
  .MOUSE_IRQ_I(MOUSE_IRQ_I), .KEY_PRESS_I(KEY_PRESS_I), .WDOG_TRIGGER_O(WDOG_TRIGGER_O),
  .WDOG_RUNNING_O(WDOG_RUNNING_O)
);
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the board watchdog, reads scored from a queue
// assumes short time base parameters so every countdown fits the run
`timescale 1ns/1ns
`default_nettype none
module testbench
  import wdog_pkg::*;
;
  localparam int SC = 10;
  localparam int MS = 3;

  logic             clk   = 1'b0;
  logic             rst   = 1'b1;
  logic             wr    = 1'b0;
  logic             rd    = 1'b0;
  logic             kbd   = 1'b0;
  logic             mouse = 1'b0;
  logic             key   = 1'b0;
  logic             rd_d  = 1'b0;
  logic [IO_AW-1:0] addr  = ADDR_UNIT;
  logic [7:0]       wdata = 8'h00;
  logic [7:0]       rdata;
  logic             trig;
  logic             run;
  logic [9:0]       exp_q[$];
  int               err_count = 0;
  int               tests_run = 0;

  always #20 clk = ~clk;

  programmable_board_watchdog #(.SEC_CYC(SC), .MIN_SEC(MS)) programmable_board_watchdog_i (
    .MCLK_I(clk), .RESET_I(rst), .IO_ADDR_I(addr), .IO_WDATA_I(wdata), .IO_WR_I(wr),
    .IO_RD_I(rd), .IO_RDATA_O(rdata), .KBD_IRQ_I(kbd), .MOUSE_IRQ_I(mouse),
    .KEY_PRESS_I(key), .WDOG_TRIGGER_O(trig), .WDOG_RUNNING_O(run)
  );

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // expected word is running, trigger, read data
  task automatic rd_reg(input logic [15:0] a, input logic [9:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    exp_q.push_back(e);
    rd   <= 1'b0;
  endtask

  // held three cycles so the pin filter sees it
  task automatic pulse(input logic k, input logic m, input logic p);
    @(posedge clk);
    kbd   <= k;
    mouse <= m;
    key   <= p;
    idle(3);
    kbd   <= 1'b0;
    mouse <= 1'b0;
    key   <= 1'b0;
  endtask

  task automatic run_case(input logic [7:0] unit, input logic [7:0] v);
    int cyc;
    cyc = v * (unit[UNIT_SEC_BIT] ? SC : SC * MS);
    wr_reg(ADDR_UNIT, unit);
    rd_reg(ADDR_UNIT, {2'b00, unit});
    wr_reg(ADDR_VALUE, v);
    idle(cyc - 8);
    rd_reg(ADDR_CTRL, 10'h200);
    idle(10);
    rd_reg(ADDR_CTRL, 10'h101);
    wr_reg(ADDR_VALUE, VALUE_OFF);
    rd_reg(ADDR_CTRL, 10'h000);
  endtask

  // restart lands near cycle 21, so a read at 36 tells both outcomes apart
  task automatic irq_case(input logic [7:0] cfg, input logic k, input logic m, input logic [9:0] e);
    wr_reg(ADDR_UNIT, 8'h80);
    wr_reg(ADDR_CFG, cfg);
    rd_reg(ADDR_CFG, {2'b00, cfg});
    wr_reg(ADDR_VALUE, 8'h03);
    idle(16);
    pulse(k, m, 1'b0);
    idle(14);
    rd_reg(ADDR_CTRL, e);
    wr_reg(ADDR_VALUE, VALUE_OFF);
  endtask

  // ----
  // scoreboard
  // ----
  always @(posedge clk) begin
    rd_d <= rd && !rst;
    if (rd_d) begin
      check({run, trig, rdata}, exp_q.pop_front());
    end
  end

  // ----
  // sequence
  // ----
  initial begin
    void'($urandom(32'h5FE3AC1F));
    idle(5);
    rst <= 1'b0;
    wr_reg(16'h0564, 8'($urandom));
    wr_reg(16'h0569, 8'($urandom));
    for (int a = 16'h0564; a <= 16'h0569; a++) begin
      rd_reg(16'(a), 10'h000);
    end
    run_case(8'h80, 8'h01);
    run_case(8'h80, 8'($urandom_range(2, 20)));
    run_case(8'h80, 8'hFF);
    run_case(8'h00, 8'h02);
    irq_case(8'h02, 1'b1, 1'b0, 10'h200);
    irq_case(8'h02, 1'b0, 1'b1, 10'h101);
    irq_case(8'h04, 1'b0, 1'b1, 10'h200);
    irq_case(8'h04, 1'b1, 1'b0, 10'h101);
    wr_reg(ADDR_VALUE, 8'hFF);
    wr_reg(ADDR_CTRL, 8'h08);
    pulse(1'b0, 1'b0, 1'b1);
    idle(6);
    rd_reg(ADDR_CTRL, 10'h109);
    wr_reg(ADDR_VALUE, VALUE_OFF);
    wr_reg(ADDR_CTRL, 8'h00);
    wr_reg(ADDR_VALUE, 8'hFF);
    pulse(1'b0, 1'b0, 1'b1);
    idle(6);
    rd_reg(ADDR_CTRL, 10'h200);
    wr_reg(ADDR_CTRL, 8'h04);
    rd_reg(ADDR_CTRL, 10'h101);
    wr_reg(ADDR_VALUE, VALUE_OFF);
    wr_reg(ADDR_CTRL, 8'h04);
    rd_reg(ADDR_CTRL, 10'h000);
    idle(3);
    finish_test();
  end

  // the whole run needs under 4000 cycles
  initial begin
    idle(20000);
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
